/* logic/cbo_core.sv */
// executes command, single-register and decimal-adjust instructions
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`default_nettype none
module cbo_core
   import cbo_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   output logic      [15:0] mem_addr_out,
   output logic      [7:0]  mem_wdata_out,
   output logic             mem_rd_out,
   output logic             mem_wr_out,
   input  wire logic [7:0]  mem_rdata_in,
   output logic      [7:0]  io_port_out,
   output logic      [7:0]  io_wdata_out,
   output logic             io_rd_out,
   output logic             io_wr_out,
   input  wire logic [7:0]  io_rdata_in,
   input  wire logic        irq_in,
   input  wire logic [7:0]  irq_opcode_in,
   output logic             irq_ack_out,
   output logic      [7:0]  acc_out,
   output logic      [7:0]  flags_out,
   output logic      [15:0] pc_out,
   output logic      [15:0] sp_out,
   output logic             irq_enable_out,
   output logic             halted_out,
   output logic             unsupported_out
);
   import cbo_pkg::*;

   // processor state
   cbo_state_t  state;
   logic [15:0] pc;              // program counter
   logic [15:0] sp;              // stack pointer
   logic [7:0]  acc;             // accumulator
   logic        f_sign, f_zero, f_aux, f_par, f_carry;
   logic        irq_en;          // interrupt enable flop
   logic [7:0]  opcode;          // current opcode
   logic [7:0]  io_dev;          // port number from second byte
   logic [7:0]  operand;         // memory operand byte
   logic [15:0] push_val;        // value pushed by restart

   // irq pin is asynchronous to us: two-stage sync
   logic irq_meta, irq_sync;
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         irq_meta <= 1'b0;
         irq_sync <= 1'b0;
      end
      else
      begin
         irq_meta <= irq_in;
         irq_sync <= irq_meta;
      end
   end

   // register file signals
   logic       rf_wr;
   logic [7:0] rf_wdata, rf_rdata, reg_h, reg_l;

   // decode helpers
   function automatic logic is_step_op(input logic [7:0] op);
      // inc or dec on a register or memory
      return op[7:6] == 2'b00 && op[2:1] == 2'b10;
   endfunction
   function automatic logic is_rst_op(input logic [7:0] op);
      return op[7:6] == 2'b11 && op[2:0] == 3'b111;
   endfunction
   function automatic logic even_parity(input logic [7:0] v);
      return ~^v;
   endfunction

   // register field picks the register file entry
   // the read uses the field of the byte just fetched
   cbo_regfile u_regs (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (rf_wr),
      .wr_sel_in   (opcode[5:3]),
      .wr_data_in  (rf_wdata),
      .rd_sel_in   (mem_rdata_in[5:3]),
      .rd_data_out (rf_rdata),
      .h_out       (reg_h),
      .l_out       (reg_l)
   );

   // increment / decrement arithmetic on the chosen byte
   logic [7:0] step_src, step_res;
   logic       step_aux;
   always_comb
   begin
      step_src = (opcode[5:3] == REG_MEM) ? operand : rf_rdata;
      step_src = (opcode[5:3] == REG_ACC) ? acc : step_src;
      if (opcode[0])
      begin
         step_res = step_src - 8'h01;
         step_aux = step_src[3:0] != 4'h0;
      end
      else
      begin
         step_res = step_src + 8'h01;
         step_aux = step_src[3:0] == 4'hF;
      end
   end

   // decimal adjust in two steps
   logic [8:0] bcd_one, bcd_two;
   logic       bcd_aux, bcd_carry;
   always_comb
   begin
      // low nibble over nine or aux set
      bcd_aux = (acc[3:0] > BCD_MAX_DIGIT) || f_aux;
      bcd_one = {1'b0, acc} + (bcd_aux ? {1'b0, BCD_LOW_FIX} : 9'h000);
      // high nibble over nine or carry set
      bcd_carry = (bcd_one[7:4] > BCD_MAX_DIGIT) || f_carry || bcd_one[8];
      bcd_two = {1'b0, bcd_one[7:0]} + (bcd_carry ? {1'b0, BCD_HIGH_FIX} : 9'h000);
   end

   logic [7:0] step_lookahead;
   assign step_lookahead = opcode;

   // main sequencer: pc, state, memory and port strobes
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state    <= CBO_FETCH;
         pc       <= PC_RESET;
         sp       <= SP_RESET;
         opcode   <= IDLE_OP;
         io_dev   <= 8'h00;
         operand  <= 8'h00;
         push_val <= 16'h0000;
      end
      else
      begin
         case (state)
            CBO_FETCH:
            begin
               // accepted request takes the place of a fetch
               if (irq_sync && irq_en)
               begin
                  opcode   <= irq_opcode_in;
                  push_val <= pc;
                  // device opcode decides the service vector
                  state    <= is_rst_op(irq_opcode_in) ? CBO_PUSH_HI : CBO_TRAP;
               end
               else
               begin
                  // first byte is always the opcode
                  opcode <= mem_rdata_in;
                  pc     <= pc + 16'h0001;
                  if (mem_rdata_in == OP_PORT_IN || mem_rdata_in == OP_PORT_OUT)
                     state <= CBO_OPERAND;
                  else if (mem_rdata_in == STOP_WAIT_OP)
                     state <= CBO_HALTED;
                  else if (is_rst_op(mem_rdata_in))
                  begin
                     push_val <= pc + 16'h0001;
                     state    <= CBO_PUSH_HI;
                  end
                  else if (is_step_op(mem_rdata_in) && mem_rdata_in[5:3] == REG_MEM)
                     state <= CBO_MEM_RD;
                  else if (is_step_op(mem_rdata_in) || mem_rdata_in == IDLE_OP
                           || mem_rdata_in == IRQ_ALLOW_OP || mem_rdata_in == IRQ_BLOCK_OP
                           || mem_rdata_in == CARRY_FLIP_OP
                           || mem_rdata_in == CARRY_FORCE_OP
                           || mem_rdata_in == ACC_INVERT_OP || mem_rdata_in == BCD_FIX_OP)
                     state <= CBO_FETCH;
                  else
                     // opcodes outside this block stop here
                     state <= CBO_TRAP;
               end
            end
            CBO_OPERAND:
            begin
               io_dev <= mem_rdata_in;
               pc     <= pc + 16'h0001;
               state  <= CBO_IO;
            end
            CBO_IO:
               state <= CBO_FETCH;
            CBO_MEM_RD:
            begin
               operand <= mem_rdata_in;
               state   <= CBO_MEM_WR;
            end
            CBO_MEM_WR:
               state <= CBO_FETCH;
            CBO_PUSH_HI:
               state <= CBO_PUSH_LO;
            CBO_PUSH_LO:
            begin
               // low byte at sp-2, then sp down two
               sp    <= sp - 16'h0002;
               // vector is field times eight in page zero
               pc    <= {8'h00, 2'b00, opcode[5:3], 3'b000};
               state <= CBO_FETCH;
            end
            CBO_HALTED:
               // only an accepted interrupt leaves here
               if (irq_sync && irq_en)
                  state <= CBO_FETCH;
            CBO_TRAP:
               state <= CBO_TRAP;
            default:
               state <= CBO_FETCH;
         endcase
      end
   end

   // interrupt enable flop
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         irq_en <= 1'b0;
      else if (state == CBO_FETCH && !(irq_sync && irq_en))
      begin
         if (mem_rdata_in == IRQ_ALLOW_OP)
            irq_en <= 1'b1;
         else if (mem_rdata_in == IRQ_BLOCK_OP)
            irq_en <= 1'b0;
      end
   end

   // one-byte ops complete on the cycle after their fetch
   logic just_fetched;
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         just_fetched <= 1'b0;
      else
         just_fetched <= state == CBO_FETCH && !(irq_sync && irq_en);
   end

   // accumulator and flags; write-back of a stepped accumulator
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         acc     <= REG_RESET;
         f_sign  <= 1'b0;
         f_zero  <= 1'b0;
         f_aux   <= 1'b0;
         f_par   <= 1'b0;
         f_carry <= 1'b0;
      end
      else if (state == CBO_IO && opcode == OP_PORT_IN)
         // port data into accumulator, flags untouched
         acc <= io_rdata_in;
      else if ((just_fetched && state == CBO_FETCH || state == CBO_MEM_WR)
               && is_step_op(step_lookahead))
      begin
         f_sign <= step_res[7];
         f_zero <= step_res == 8'h00;
         f_par  <= even_parity(step_res);
         f_aux  <= step_aux;
         if (opcode[5:3] == REG_ACC)
            acc <= step_res;
      end
      else if (just_fetched && state == CBO_FETCH)
      begin
         case (opcode)
            CARRY_FLIP_OP:  f_carry <= ~f_carry;
            CARRY_FORCE_OP: f_carry <= 1'b1;
            ACC_INVERT_OP:  acc <= ~acc;
            BCD_FIX_OP:
            begin
               // all five flags: sign, zero and parity from the adjusted value, aux and carry from the fixes
               acc     <= bcd_two[7:0];
               f_sign  <= bcd_two[7];
               f_zero  <= bcd_two[7:0] == 8'h00;
               f_par   <= even_parity(bcd_two[7:0]);
               f_aux   <= bcd_aux;
               f_carry <= bcd_carry || bcd_two[8];
            end
            // idle and the rest change nothing here
            default: ;
         endcase
      end
   end

   // register file write for stepped B..L
   always_comb
   begin
      rf_wdata = step_res;
      rf_wr = just_fetched && state == CBO_FETCH && is_step_op(opcode)
              && opcode[5:3] != REG_MEM && opcode[5:3] != REG_ACC;
   end

   // bus drive
   always_comb
   begin
      mem_addr_out  = pc;
      mem_wdata_out = 8'h00;
      mem_rd_out    = 1'b0;
      mem_wr_out    = 1'b0;
      case (state)
         CBO_FETCH, CBO_OPERAND: mem_rd_out = !(state == CBO_FETCH && irq_sync && irq_en);
         CBO_MEM_RD:
         begin
            mem_addr_out = {reg_h, reg_l};
            mem_rd_out   = 1'b1;
         end
         CBO_MEM_WR:
         begin
            mem_addr_out  = {reg_h, reg_l};
            mem_wdata_out = step_res;
            mem_wr_out    = 1'b1;
         end
         CBO_PUSH_HI:
         begin
            mem_addr_out  = sp - 16'h0001;
            mem_wdata_out = push_val[15:8];
            mem_wr_out    = 1'b1;
         end
         CBO_PUSH_LO:
         begin
            mem_addr_out  = sp - 16'h0002;
            mem_wdata_out = push_val[7:0];
            mem_wr_out    = 1'b1;
         end
         default: ;
      endcase
   end

   assign io_port_out  = io_dev;
   assign io_wdata_out = acc;
   assign io_rd_out    = state == CBO_IO && opcode == OP_PORT_IN;
   assign io_wr_out    = state == CBO_IO && opcode == OP_PORT_OUT;
   // request accepted in fetch or stop state drives the acknowledge
   assign irq_ack_out  = (state == CBO_FETCH || state == CBO_HALTED) && irq_sync && irq_en;

   // flag byte, bit 3 and 5 zero, bit 1 one
   // this byte pairs with acc as the flags pair
   always_comb
   begin
      flags_out = 8'h00;
      flags_out[FLAG_SIGN_BIT]  = f_sign;
      flags_out[FLAG_ZERO_BIT]  = f_zero;
      flags_out[FLAG_AUX_BIT]   = f_aux;
      flags_out[FLAG_PAR_BIT]   = f_par;
      flags_out[FLAG_ONE_BIT]   = 1'b1;
      flags_out[FLAG_CARRY_BIT] = f_carry;
   end

   assign acc_out         = acc;
   assign pc_out          = pc;
   assign sp_out          = sp;
   assign irq_enable_out  = irq_en;
   assign halted_out      = state == CBO_HALTED;
   assign unsupported_out = state == CBO_TRAP;

   chk_carry_force: assert property (@(posedge clk_in) disable iff (reset_in)
      just_fetched && state == CBO_FETCH && opcode == CARRY_FORCE_OP |=> f_carry)
      else $error("carry not forced");
   chk_carry_flip: assert property (@(posedge clk_in) disable iff (reset_in)
      just_fetched && state == CBO_FETCH && opcode == CARRY_FLIP_OP
      |=> f_carry != $past(f_carry))
      else $error("carry not flipped");
   chk_acc_invert: assert property (@(posedge clk_in) disable iff (reset_in)
      just_fetched && state == CBO_FETCH && opcode == ACC_INVERT_OP
      |=> acc == ~$past(acc) && flags_out == $past(flags_out))
      else $error("accumulator not inverted");
   chk_stop_stays: assert property (@(posedge clk_in) disable iff (reset_in)
      state == CBO_HALTED && !irq_en |=> state == CBO_HALTED)
      else $error("left stop while blocked");
   chk_rst_vector: assert property (@(posedge clk_in) disable iff (reset_in)
      state == CBO_PUSH_LO |=> pc == {10'h000, $past(opcode[5:3]), 3'b000})
      else $error("wrong restart vector");
   chk_push_order: assert property (@(posedge clk_in) disable iff (reset_in)
      state == CBO_PUSH_HI |-> mem_addr_out == sp - 16'h0001 ##1
      mem_addr_out == sp - 16'h0002 ##1 sp == $past(sp, 2) - 16'h0002)
      else $error("push order wrong");
   chk_port_in: assert property (@(posedge clk_in) disable iff (reset_in)
      io_rd_out |=> acc == $past(io_rdata_in))
      else $error("port input lost");
   chk_irq_allow: assert property (@(posedge clk_in) disable iff (reset_in)
      state == CBO_FETCH && !irq_ack_out && mem_rdata_in == IRQ_ALLOW_OP |=> irq_en)
      else $error("enable not set");
endmodule
`default_nettype wire

/* common/cbo_pkg.sv */
// constants shared by the control and byte-op execution block
`default_nettype none
package cbo_pkg;
   // opcodes handled here
   localparam logic [7:0] OP_PORT_IN     = 8'hDB;
   localparam logic [7:0] OP_PORT_OUT    = 8'hD3;
   localparam logic [7:0] IRQ_ALLOW_OP   = 8'hFB;
   localparam logic [7:0] IRQ_BLOCK_OP   = 8'hF3;
   localparam logic [7:0] STOP_WAIT_OP   = 8'h76;
   localparam logic [7:0] CARRY_FLIP_OP  = 8'h3F;
   localparam logic [7:0] CARRY_FORCE_OP = 8'h37;
   localparam logic [7:0] IDLE_OP        = 8'h00;
   localparam logic [7:0] ACC_INVERT_OP  = 8'h2F;
   localparam logic [7:0] BCD_FIX_OP     = 8'h27;
   // register field codes
   localparam logic [2:0] REG_B   = 3'h0;
   localparam logic [2:0] REG_C   = 3'h1;
   localparam logic [2:0] REG_D   = 3'h2;
   localparam logic [2:0] REG_E   = 3'h3;
   localparam logic [2:0] REG_H   = 3'h4;
   localparam logic [2:0] REG_L   = 3'h5;
   localparam logic [2:0] REG_MEM = 3'h6;
   localparam logic [2:0] REG_ACC = 3'h7;
   // register-pair field codes
   localparam logic [1:0] PAIR_BC        = 2'h0;
   localparam logic [1:0] PAIR_DE        = 2'h1;
   localparam logic [1:0] PAIR_HL        = 2'h2;
   localparam logic [1:0] FLAGS_ACC_PAIR = 2'h3;
   // flag byte layout
   localparam int FLAG_SIGN_BIT  = 7;
   localparam int FLAG_ZERO_BIT  = 6;
   localparam int FLAG_AUX_BIT   = 4;
   localparam int FLAG_PAR_BIT   = 2;
   localparam int FLAG_ONE_BIT   = 1;
   localparam int FLAG_CARRY_BIT = 0;
   // decimal adjust figures
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [7:0] BCD_LOW_FIX   = 8'h06;
   localparam logic [7:0] BCD_HIGH_FIX  = 8'h60;
   // reset values
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [7:0]  REG_RESET = 8'h00;
   // sequencer states
   typedef enum logic [3:0] {
      CBO_FETCH, CBO_OPERAND, CBO_MEM_RD, CBO_MEM_WR, CBO_IO,
      CBO_PUSH_HI, CBO_PUSH_LO, CBO_HALTED, CBO_TRAP
   } cbo_state_t;
endpackage
`default_nettype wire

/* logic/cbo_regfile.sv */
// eight-entry byte register file, registered read port
`default_nettype none
module cbo_regfile
   import cbo_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       wr_en_in,
   input  wire logic [2:0] wr_sel_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic [2:0] rd_sel_in,
   output logic      [7:0] rd_data_out,
   output logic      [7:0] h_out,
   output logic      [7:0] l_out
);
   import cbo_pkg::*;
   // storage; entry 6 (memory code) is never written
   logic [7:0] regs [8];

   // write port, one loop per entry
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_reg
         always_ff @(posedge clk_in or posedge reset_in)
         begin
            if (reset_in)
               regs[gi] <= REG_RESET;
            else if (wr_en_in && wr_sel_in == 3'(gi))
               regs[gi] <= wr_data_in;
         end
      end
   endgenerate

   // registered read, so data lags the select by one cycle
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         rd_data_out <= REG_RESET;
      else if (wr_en_in && wr_sel_in == rd_sel_in)
         // write-through: a step right after a step of the same entry sees the new value
         rd_data_out <= wr_data_in;
      else
         rd_data_out <= regs[rd_sel_in];
   end

   // address pair is always visible for memory operands
   assign h_out = regs[REG_H];
   assign l_out = regs[REG_L];
endmodule
`default_nettype wire

/* verification/cbo_far_side.sv */
// behavioural memory and numbered port devices facing the core
`default_nettype none
module cbo_far_side
(
   input  wire logic        clk_in,
   input  wire logic [15:0] mem_addr_in,
   input  wire logic [7:0]  mem_wdata_in,
   input  wire logic        mem_rd_in,
   input  wire logic        mem_wr_in,
   output logic      [7:0]  mem_rdata_out,
   input  wire logic [7:0]  io_port_in,
   input  wire logic [7:0]  io_wdata_in,
   input  wire logic        io_rd_in,
   input  wire logic        io_wr_in,
   output logic      [7:0]  io_rdata_out,
   input  wire logic        irq_ack_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] mem [0:65535];   // flat byte store
   logic [7:0] last_rd;         // last byte handed out
   logic [7:0] wr_port [0:7];   // log of port numbers written
   logic [7:0] wr_data [0:7];   // log of port data written
   int         wr_cnt;          // port writes seen
   int         ack_cnt;         // acknowledges seen

   // clear store and counters
   initial
   begin
      last_rd = 8'h00;
      wr_cnt  = 0;
      ack_cnt = 0;
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h00;
   end

   // byte at the presented address
   // idle bus shows the inverse of the last byte, so stale data cannot pass
   assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in] : ~last_rd;

   // store writes, remember reads
   always @(posedge clk_in)
   begin
      if (mem_rd_in)
         last_rd <= mem[mem_addr_in];
      if (mem_wr_in)
         mem[mem_addr_in] <= mem_wdata_in;
   end

   // device answers with a value keyed to its number
   assign io_rdata_out = io_rd_in ? (io_port_in ^ 8'h5A) : ~io_port_in;

   always @(posedge clk_in)
   begin
      if (io_wr_in && wr_cnt < 8)
      begin
         wr_port[wr_cnt] <= io_port_in;
         wr_data[wr_cnt] <= io_wdata_in;
      end
      if (io_wr_in)
         wr_cnt <= wr_cnt + 1;
      if (irq_ack_in)
         ack_cnt <= ack_cnt + 1;
   end
endmodule
`default_nettype wire

/* verification/tb_cpu_control_and_byte_ops.sv */
// self-checking bench for the control and byte-op core
`default_nettype none
module tb_cpu_control_and_byte_ops;
   import cbo_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   // program: in, out, carry ops, bcd fix, invert, inc, mem inc, idle, bcd fix, out, block, stop
   localparam logic [7:0] PROG1 [16] = '{OP_PORT_IN, 8'h10, OP_PORT_OUT, 8'h20,
      CARRY_FORCE_OP, CARRY_FLIP_OP, BCD_FIX_OP, ACC_INVERT_OP, 8'h3C, 8'h34,
      IDLE_OP, BCD_FIX_OP, OP_PORT_OUT, 8'h21, IRQ_BLOCK_OP, STOP_WAIT_OP};

   logic        clk_in = 1'b0;   // 50 MHz
   logic        reset_in;        // async, active high
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic        mem_rd;
   logic        mem_wr;
   logic [7:0]  mem_rdata;
   logic [7:0]  io_port;
   logic [7:0]  io_wdata;
   logic        io_rd;
   logic        io_wr;
   logic [7:0]  io_rdata;
   logic        irq;             // request from the device side
   logic [7:0]  irq_opcode;      // opcode offered on accept
   logic        irq_ack;
   logic [7:0]  acc;
   logic [7:0]  flags;
   logic [15:0] pc;
   logic [15:0] sp;
   logic        irq_en;
   logic        halted;
   logic        unsupported;
   int          mismatches = 0;
   int          n_compared = 0;
   int          acks;            // acknowledge count snapshot
   int          n;               // bounded wait counter

   always #10 clk_in = ~clk_in;

   cbo_core dut_u (.clk_in(clk_in), .reset_in(reset_in), .mem_addr_out(mem_addr),
      .mem_wdata_out(mem_wdata), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr),
      .mem_rdata_in(mem_rdata), .io_port_out(io_port), .io_wdata_out(io_wdata),
      .io_rd_out(io_rd), .io_wr_out(io_wr), .io_rdata_in(io_rdata), .irq_in(irq),
      .irq_opcode_in(irq_opcode), .irq_ack_out(irq_ack), .acc_out(acc),
      .flags_out(flags), .pc_out(pc), .sp_out(sp), .irq_enable_out(irq_en),
      .halted_out(halted), .unsupported_out(unsupported));

   cbo_far_side far_u (.clk_in(clk_in), .mem_addr_in(mem_addr),
      .mem_wdata_in(mem_wdata), .mem_rd_in(mem_rd), .mem_wr_in(mem_wr),
      .mem_rdata_out(mem_rdata), .io_port_in(io_port), .io_wdata_in(io_wdata),
      .io_rd_in(io_rd), .io_wr_in(io_wr), .io_rdata_out(io_rdata),
      .irq_ack_in(irq_ack));

   // compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // wait on falling edges so outputs are settled
   task automatic wait_halt(input logic [15:0] at);
      n = 0;
      while (!(halted === 1'b1 && pc === at) && n < 600)
      begin
         @(negedge clk_in);
         n++;
      end
      check(pc, at, "stop address");
      check(halted, 1'b1, "stopped");
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog, far beyond the hundred or so cycles the tests need
   initial
   begin
      #(5000 * 20);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   initial
   begin
      reset_in   = 1'b1;
      irq        = 1'b0;
      irq_opcode = 8'h00;
      // load after the model has cleared its store
      @(posedge clk_in);
      for (int i = 0; i < 16; i++)
         far_u.mem[i] = PROG1[i];
      repeat (19) @(posedge clk_in);
      reset_in <= 1'b0;
      wait_halt(16'h0010);
      check(acc, 16'h0010, "acc after second fix");
      check(flags, 16'h0003, "flags after second fix");
      check(irq_en, 1'b0, "enable after block op");
      check(far_u.mem[0], 8'hDC, "memory operand inc");
      check(far_u.wr_cnt, 2, "port write count");
      check(far_u.wr_port[0], 8'h20, "first port number");
      check(far_u.wr_data[0], 8'h4A, "port input value");
      check(far_u.wr_port[1], 8'h21, "second port number");
      check(far_u.wr_data[1], 8'h10, "acc after fixes");
      check(unsupported, 1'b0, "no foreign opcode");
      // request while stopped and blocked must be ignored
      acks = far_u.ack_cnt;
      @(posedge clk_in);
      irq        <= 1'b1;
      irq_opcode <= 8'hDF;
      repeat (40) @(negedge clk_in);
      check(halted, 1'b1, "stays stopped");
      check(pc, 16'h0010, "pc kept while stopped");
      check(far_u.ack_cnt - acks, 0, "no acknowledge");
      @(posedge clk_in);
      irq      <= 1'b0;
      reset_in <= 1'b1;
      // second run: steps on H, L, memory and B, allow, stop, restart 3 from the device
      repeat (2) @(posedge clk_in);
      far_u.mem[0]        = 8'h24;              // step H up: operand page 01
      far_u.mem[1]        = 8'h2C;              // step L up twice, back to back
      far_u.mem[2]        = 8'h2C;
      far_u.mem[3]        = 8'h34;              // step the byte at 0102 up
      far_u.mem[4]        = 8'h05;              // step B down from zero
      far_u.mem[5]        = IRQ_ALLOW_OP;
      far_u.mem[6]        = STOP_WAIT_OP;
      far_u.mem[16'h0102] = 8'h7F;
      far_u.mem[16'h18]   = STOP_WAIT_OP;
      far_u.mem[16'hFFFF] = 8'hFF;              // so a missing high byte shows
      repeat (18) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      check(flags, 16'h0002, "reset flag byte");
      wait_halt(16'h0007);
      check(irq_en, 1'b1, "enable after allow op");
      @(posedge clk_in);
      irq <= 1'b1;
      n = 0;
      while (irq_ack !== 1'b1 && n < 50)
      begin
         @(negedge clk_in);
         n++;
      end
      check(irq_ack, 1'b1, "acknowledge seen");
      @(posedge clk_in);
      irq <= 1'b0;
      wait_halt(16'h0019);
      check(sp, 16'hFFFE, "stack after push");
      check(far_u.mem[16'hFFFF], 8'h00, "return high");
      check(far_u.mem[16'hFFFE], 8'h07, "return low");
      // aux after a decrement is left open, so that bit is masked
      check(flags & 8'hEF, 16'h0086, "flags kept by restart");
      check(far_u.mem[16'h0102], 8'h80, "operand via H and L");
      print_verdict();
   end
endmodule
`default_nettype wire
